// file: bench/t0cc_core_tb_top.sv
// Self-checking bench for the timer control and counter core.
// Assumes the core's one-cycle read latency and a free-running prescaler.
`timescale 1ns/1ps
`default_nettype none

module t0cc_core_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  io_addr;
    logic        io_ds;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        ovf_ack = 1'b0;
    logic        cmp_ack = 1'b0;
    logic        pin;
    logic        en;
    logic        ovf;
    logic        cmp_flag;
    logic [7:0]  d;
    logic [15:0] n;
    int          miscompares = 0;
    int          compares = 0;
    logic [1:0]  fcom [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
    logic        fpin [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int          dv [7] = '{1, 8, 32, 64, 128, 256, 1024};
    // PWM rows: control, compare, period, high cycles
    logic [7:0]  pc [5] = '{8'h69, 8'h79, 8'h29, 8'h39, 8'h69};
    logic [7:0]  pv [5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'hFF};
    logic [15:0] pp [5] = '{16'h0100, 16'h0100, 16'h01FE, 16'h01FE, 16'h0100};
    logic [15:0] ph [5] = '{16'h0081, 16'h007F, 16'h0100, 16'h00FE, 16'h0100};

    // ==========================================================
    // Clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    t0cc_core dut (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .io_addr            (io_addr),
        .io_data_space      (io_ds),
        .io_wr              (io_wr),
        .io_rd              (io_rd),
        .io_wdata           (io_wdata),
        .io_rdata           (io_rdata),
        .ovf_vector_ack     (ovf_ack),
        .cmp_vector_ack     (cmp_ack),
        .compare_output_pin (pin),
        .compare_output_en  (en),
        .overflow_flag      (ovf),
        .compare_match_flag (cmp_flag)
    );

    t0cc_host host (
        .clk_sys       (clk_sys),
        .io_addr       (io_addr),
        .io_data_space (io_ds),
        .io_wr         (io_wr),
        .io_rd         (io_rd),
        .io_wdata      (io_wdata),
        .io_rdata      (io_rdata)
    );

    // ==========================================================
    // Compare and verdict
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 11k cycles of the tests
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        host.rd(8'h32, d); chk(d, 8'h00);
        host.rd(8'h33, d); chk(d, 8'h00);
        host.rd(8'h40, d); chk(d, 8'h00);
        // Forced matches through every output mode
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h33, {2'b10, fcom[i], 4'h0});
            #1;
            if (fcom[i] != 2'h0) chk(pin, fpin[i]);
            chk(en, fcom[i] != 2'h0);
            chk(cmp_flag, 1'b0);
            host.rd(8'h53, d); chk(d, {2'b00, fcom[i], 4'h0});
        end
        host.wr(8'h52, 8'h5A);
        host.rd(8'h52, d); chk(d, 8'h5A);
        // Four ticks in a window of four divider periods, every source
        for (int i = 1; i < 8; i++) begin
            host.wr(8'h32, 8'h00);
            host.wr(8'h33, i[7:0]);
            repeat (4 * dv[i-1] - 2) @(posedge clk_sys);
            host.wr(8'h33, 8'h00);
            host.rd(8'h32, d); chk(d, 8'h04);
        end
        // Overflow at max, cleared by writing a one
        host.wr(8'h36, 8'h03);
        host.wr(8'h32, 8'hFE);
        host.wr(8'h33, 8'h01);
        @(posedge clk_sys);
        #1 chk(ovf, 1'b0);
        @(posedge clk_sys);
        #1 chk(ovf, 1'b1);
        host.wr(8'h36, 8'h01);
        #1 chk(ovf, 1'b0);
        // Overflow again after a full wrap, cleared by the vector this time
        repeat (256) @(posedge clk_sys);
        #1 chk(ovf, 1'b1);
        @(posedge clk_sys);
        ovf_ack <= 1'b1;
        @(posedge clk_sys);
        ovf_ack <= 1'b0;
        #1 chk(ovf, 1'b0);
        // Clear-on-match: first tick after a counter write has no match
        host.wr(8'h33, 8'h40);
        host.wr(8'h31, 8'h03);
        host.wr(8'h32, 8'h03);
        host.wr(8'h36, 8'h03);
        host.wr(8'h33, 8'h51);
        repeat (8) @(posedge clk_sys);
        host.rd(8'h32, d); chk(d, 8'h0C);
        chk(cmp_flag, 1'b0);
        chk(pin, 1'b0);
        host.wr(8'h33, 8'h40);
        host.wr(8'h32, 8'h00);
        host.wr(8'h36, 8'h03);
        host.wr(8'h33, 8'h51);
        repeat (20) @(posedge clk_sys);
        host.rd(8'h32, d); chk(d <= 8'h03, 1'b1);
        host.wr(8'h33, 8'h40);
        #1 chk(cmp_flag, 1'b1);
        host.rd(8'h56, d); chk(d, 8'h02);
        host.rd(8'h31, d); chk(d, 8'h03);
        @(posedge clk_sys);
        cmp_ack <= 1'b1;
        @(posedge clk_sys);
        cmp_ack <= 1'b0;
        #1 chk(cmp_flag, 1'b0);
        // Counter write onto the compare value while running: no clear next tick
        host.wr(8'h33, 8'h51);
        host.wr(8'h32, 8'h03);
        host.wr(8'h33, 8'h40);
        host.rd(8'h32, d); chk(d, 8'h05);
        // PWM duty over one period per mode and output setting
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h33, 8'h00);
            host.wr(8'h31, pv[i]);
            host.wr(8'h33, pc[i]);
            repeat (600) @(posedge clk_sys);
            n = 16'h0000;
            repeat (pp[i]) begin
                @(posedge clk_sys);
                #1 n = n + pin;
            end
            chk(n, ph[i]);
        end
        final_report();
    end
endmodule
`default_nettype wire

// file: bench/t0cc_host.sv
// Processor core model that reaches the timer through the I/O register strobes.
// Assumes one-cycle strobes taken on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none

module t0cc_host (
    // Clock
    input  wire logic       clk_sys,
    // I/O register access
    output logic      [7:0] io_addr,
    output logic            io_data_space,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        io_addr = 8'h00;
        io_data_space = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // Write; addresses above 0x3F go out as data-space addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic pwm;
        pwm = (a == 8'h33 || a == 8'h53) && d[3];
        @(posedge clk_sys);
        io_addr <= a;
        io_data_space <= a > 8'h3F;
        io_wdata <= pwm ? {1'b0, d[6:0]} : d;
        io_wr <= 1'b1;
        @(posedge clk_sys);
        io_wr <= 1'b0;
        // Released lines show the inverse, so stale data never passes
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask

    // Read; data is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        io_addr <= a;
        io_data_space <= a > 8'h3F;
        io_rd <= 1'b1;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        io_addr <= ~a;
        #1 d = io_rdata;
    endtask
endmodule
`default_nettype wire

// file: rtl/t0cc_core.sv
// Timer control register, counter, compare path and output pin of the 8-bit timer.
// Assumes the processor core gives one-cycle read and write strobes synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module t0cc_core (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // I/O register access
    input  wire logic [7:0] io_addr,
    input  wire logic       io_data_space,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // Interrupt vector execution
    input  wire logic       ovf_vector_ack,
    input  wire logic       cmp_vector_ack,
    // Waveform pin and flags
    output logic            compare_output_pin,
    output logic            compare_output_en,
    output logic            overflow_flag,
    output logic            compare_match_flag
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [6:0]                  ctrl;
        logic [7:0]                  cnt;
        logic                        dir_down;
        logic [7:0]                  cmp_buf;
        logic [7:0]                  cmp_act;
        logic [t0cc_pkg::PRESC_W-1:0] presc;
        logic                        suppress;
        logic                        ovf;
        logic                        cmf;
        logic                        pin;
        logic                        pin_en;
        logic [7:0]                  rdata;
    } t0cc_state_type;

    t0cc_state_type s_q;
    t0cc_state_type s_d;

    t0cc_pkg::t0cc_mode_type mode;
    t0cc_pkg::t0cc_mode_type new_mode;
    logic [1:0]              com;
    logic [1:0]              new_com;
    logic [2:0]              cs;
    logic                    tick;
    logic                    match;
    logic                    bottom;
    logic                    ovf_set;
    logic                    force_cmp;
    logic                    wr_ctrl;
    logic                    wr_cnt;
    logic                    wr_cmp;
    logic                    wr_flag;

    // ==========================================================
    // Functions

    // Register hit in either address space
    function automatic logic t0cc_hit(input logic [7:0] addr, input logic dspace,
                                      input logic [7:0] off);
        t0cc_hit = dspace ? (addr == (off + t0cc_pkg::DATA_SPACE_BASE)) : (addr == off);
    endfunction

    // Timer tick from the free prescaler
    function automatic logic t0cc_tick(input logic [2:0] sel,
                                       input logic [t0cc_pkg::PRESC_W-1:0] p);
        case (sel)
            3'h0:    t0cc_tick = 1'b0;
            3'h1:    t0cc_tick = 1'b1;
            3'h2:    t0cc_tick = (p & t0cc_pkg::DIV_8) == t0cc_pkg::DIV_8;
            3'h3:    t0cc_tick = (p & t0cc_pkg::DIV_32) == t0cc_pkg::DIV_32;
            3'h4:    t0cc_tick = (p & t0cc_pkg::DIV_64) == t0cc_pkg::DIV_64;
            3'h5:    t0cc_tick = (p & t0cc_pkg::DIV_128) == t0cc_pkg::DIV_128;
            3'h6:    t0cc_tick = (p & t0cc_pkg::DIV_256) == t0cc_pkg::DIV_256;
            default: t0cc_tick = (p & t0cc_pkg::DIV_1024) == t0cc_pkg::DIV_1024;
        endcase
    endfunction

    // Pin action for a non-PWM match
    function automatic logic t0cc_match_pin(input logic [1:0] c, input logic p);
        case (c)
            2'h1:    t0cc_match_pin = ~p;
            2'h2:    t0cc_match_pin = 1'b0;
            2'h3:    t0cc_match_pin = 1'b1;
            default: t0cc_match_pin = p;
        endcase
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        s_d      = s_q;
        mode     = t0cc_pkg::t0cc_mode_type'({s_q.ctrl[t0cc_pkg::CTRL_WGM_HI],
                                              s_q.ctrl[t0cc_pkg::CTRL_WGM_LO]});
        com      = s_q.ctrl[t0cc_pkg::CTRL_COM_HI:t0cc_pkg::CTRL_COM_LO];
        cs       = s_q.ctrl[t0cc_pkg::CTRL_CS_HI:t0cc_pkg::CTRL_CS_LO];
        new_mode = t0cc_pkg::t0cc_mode_type'({io_wdata[t0cc_pkg::CTRL_WGM_HI],
                                              io_wdata[t0cc_pkg::CTRL_WGM_LO]});
        new_com  = io_wdata[t0cc_pkg::CTRL_COM_HI:t0cc_pkg::CTRL_COM_LO];
        wr_ctrl  = io_wr && t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_CONTROL);
        wr_cnt   = io_wr && t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_COUNTER);
        wr_cmp   = io_wr && t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_COMPARE);
        wr_flag  = io_wr && t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_FLAGS);
        tick     = t0cc_tick(cs, s_q.presc);
        // A tick just after a counter write sees no match
        match    = tick && (s_q.cnt == s_q.cmp_act) && !s_q.suppress;
        bottom   = 1'b0;
        ovf_set  = 1'b0;
        force_cmp = 1'b0;

        // Prescaler runs free so ticks stay on a fixed grid
        s_d.presc = s_q.presc + 1'b1;

        // Counting, top and overflow per mode
        if (tick) begin
            s_d.suppress = 1'b0;
            case (mode)
                t0cc_pkg::MODE_NORMAL: begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    ovf_set = (s_q.cnt == t0cc_pkg::COUNT_MAX);
                end
                t0cc_pkg::MODE_CLEAR_ON_MATCH: begin
                    s_d.cnt = match ? t0cc_pkg::COUNT_BOTTOM : s_q.cnt + 8'h01;
                    ovf_set = (s_q.cnt == t0cc_pkg::COUNT_MAX);
                end
                t0cc_pkg::MODE_FAST_PWM: begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    ovf_set = (s_q.cnt == t0cc_pkg::COUNT_MAX);
                    bottom  = (s_q.cnt == t0cc_pkg::COUNT_MAX);
                end
                t0cc_pkg::MODE_PHASE_PWM: begin
                    if (!s_q.dir_down) begin
                        if (s_q.cnt == t0cc_pkg::COUNT_MAX) begin
                            s_d.dir_down = 1'b1;
                            s_d.cnt      = s_q.cnt - 8'h01;
                        end else begin
                            s_d.cnt = s_q.cnt + 8'h01;
                        end
                    end else begin
                        if (s_q.cnt == t0cc_pkg::COUNT_BOTTOM) begin
                            s_d.dir_down = 1'b0;
                            s_d.cnt      = s_q.cnt + 8'h01;
                            ovf_set      = 1'b1;
                        end else begin
                            s_d.cnt = s_q.cnt - 8'h01;
                        end
                    end
                end
                default: begin
                    s_d.cnt = s_q.cnt;
                end
            endcase
        end

        // Compare buffer update point per mode
        if (wr_cmp) begin
            s_d.cmp_buf = io_wdata;
        end
        case (mode)
            t0cc_pkg::MODE_FAST_PWM: begin
                if (bottom) begin
                    s_d.cmp_act = s_q.cmp_buf;
                end
            end
            t0cc_pkg::MODE_PHASE_PWM: begin
                if (tick && !s_q.dir_down && s_q.cnt == t0cc_pkg::COUNT_MAX) begin
                    s_d.cmp_act = s_q.cmp_buf;
                end
            end
            default: begin
                s_d.cmp_act = s_d.cmp_buf;
            end
        endcase

        // Waveform pin
        case (mode)
            t0cc_pkg::MODE_FAST_PWM: begin
                if (com[1]) begin
                    if (match && s_q.cmp_act != t0cc_pkg::COUNT_MAX) begin
                        s_d.pin = com[0];
                    end
                    if (bottom) begin
                        s_d.pin = ~com[0];
                    end
                end
            end
            t0cc_pkg::MODE_PHASE_PWM: begin
                if (com[1]) begin
                    if (s_q.cmp_act == t0cc_pkg::COUNT_MAX) begin
                        if (tick && !s_q.dir_down && s_q.cnt == t0cc_pkg::COUNT_MAX) begin
                            s_d.pin = ~com[0];
                        end
                    end else if (match) begin
                        s_d.pin = s_q.dir_down ? ~com[0] : com[0];
                    end
                end
            end
            default: begin
                if (match) begin
                    s_d.pin = t0cc_match_pin(com, s_q.pin);
                end
            end
        endcase

        // Control write, force strobe is acted on in non-PWM modes and never stored
        if (wr_ctrl) begin
            s_d.ctrl = io_wdata[6:0];
            if (io_wdata[t0cc_pkg::CTRL_FORCE_BIT] &&
                (new_mode == t0cc_pkg::MODE_NORMAL ||
                 new_mode == t0cc_pkg::MODE_CLEAR_ON_MATCH)) begin
                force_cmp = 1'b1;
                // No flag and no counter clear from here
                s_d.pin = t0cc_match_pin(new_com, s_q.pin);
            end
        end
        s_d.pin_en = |s_d.ctrl[t0cc_pkg::CTRL_COM_HI:t0cc_pkg::CTRL_COM_LO];

        // Counter write wins over a tick and masks the next match
        if (wr_cnt) begin
            s_d.cnt      = io_wdata;
            s_d.suppress = 1'b1;
        end

        // Flags, a new event beats a clear in the same cycle
        if (ovf_vector_ack || (wr_flag && io_wdata[t0cc_pkg::FLAG_OVF_BIT])) begin
            s_d.ovf = 1'b0;
        end
        if (cmp_vector_ack || (wr_flag && io_wdata[t0cc_pkg::FLAG_CMP_BIT])) begin
            s_d.cmf = 1'b0;
        end
        if (ovf_set) begin
            s_d.ovf = 1'b1;
        end
        if (match) begin
            s_d.cmf = 1'b1;
        end

        // Read data, unmapped addresses read zero
        s_d.rdata = t0cc_pkg::RESET_BYTE;
        if (io_rd) begin
            if (t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_CONTROL)) begin
                s_d.rdata = {1'b0, s_q.ctrl};
            end else if (t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_COUNTER)) begin
                s_d.rdata = s_q.cnt;
            end else if (t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_COMPARE)) begin
                s_d.rdata = s_q.cmp_buf;
            end else if (t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_FLAGS)) begin
                s_d.rdata = {6'h00, s_q.cmf, s_q.ovf};
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state
    assign io_rdata           = s_q.rdata;
    assign compare_output_pin = s_q.pin;
    assign compare_output_en  = s_q.pin_en;
    assign overflow_flag      = s_q.ovf;
    assign compare_match_flag = s_q.cmf;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_force_reads_zero: assert property (
        io_rd && t0cc_hit(io_addr, io_data_space, t0cc_pkg::OFF_CONTROL) |=> io_rdata[7] == 1'b0)
        else $error("force strobe bit read back as one");

    chk_force_no_flag: assert property (
        force_cmp && !match |=> !$rose(compare_match_flag))
        else $error("forced match set the compare flag");

    chk_force_clear_pin: assert property (
        force_cmp && new_com == 2'h2 && !wr_cnt |=> compare_output_pin == 1'b0)
        else $error("forced match did not clear the pin");

    chk_pin_override_on: assert property (
        wr_ctrl && new_com != 2'h0 |=> compare_output_en ##1 compare_output_en || wr_ctrl)
        else $error("nonzero output mode did not enable the pin");

    chk_normal_wrap_ovf: assert property (
        tick && mode == t0cc_pkg::MODE_NORMAL && s_q.cnt == 8'hFF && !wr_cnt
        |=> s_q.cnt == 8'h00 && overflow_flag)
        else $error("normal mode did not wrap with overflow");

    chk_ctc_clears: assert property (
        match && mode == t0cc_pkg::MODE_CLEAR_ON_MATCH && !wr_cnt |=> s_q.cnt == 8'h00)
        else $error("clear-on-match did not clear the counter");

    chk_write_blocks_match: assert property (
        wr_cnt ##1 (!wr_cnt && tick) |-> !match)
        else $error("match not blocked after counter write");

    chk_phase_turn_top: assert property (
        tick && mode == t0cc_pkg::MODE_PHASE_PWM && !s_q.dir_down && s_q.cnt == 8'hFF && !wr_cnt
        |=> s_q.dir_down && s_q.cnt == 8'hFE)
        else $error("phase mode did not turn at top");

    chk_phase_ovf_bottom: assert property (
        tick && mode == t0cc_pkg::MODE_PHASE_PWM && s_q.dir_down && s_q.cnt == 8'h00
        |=> overflow_flag && !s_q.dir_down)
        else $error("phase mode overflow not at bottom");

    chk_stopped_clock: assert property (
        cs == 3'h0 |-> !tick ##1 (cs != 3'h0 || $stable(s_q.cnt) || $past(wr_cnt)))
        else $error("counter moved with clock stopped");

    chk_div8_grid: assert property (
        cs == 3'h2 && tick |-> s_q.presc[2:0] == 3'h7)
        else $error("divide-by-8 tick off grid");

    chk_flag_write_clear: assert property (
        wr_flag && io_wdata[0] && !ovf_set |=> !overflow_flag)
        else $error("overflow flag not cleared by writing one");

    chk_data_space_alias: assert property (
        io_rd && io_data_space && io_addr == 8'h52 |=> io_rdata == $past(s_q.cnt))
        else $error("counter not readable in data space");

    cov_fast_bottom: cover property (bottom && com == 2'h2);
    cov_phase_reverse: cover property (tick && s_q.dir_down && s_q.cnt == 8'h00);
    cov_force: cover property (force_cmp);
    cov_ctc_clear: cover property (match && mode == t0cc_pkg::MODE_CLEAR_ON_MATCH);

endmodule

`default_nettype wire

// file: rtl/t0cc_pkg.sv
// Constants, field layout and mode types of the 8-bit timer control and counter core.
// Assumes one synchronous I/O clock and the processor core's I/O register strobes.
//
// Notes on behaviour
// - Force strobe in non-PWM mode makes an immediate match acting on the pin.
// - Forced match sets no flag and never clears the counter.
// - Force strobe bit holds no state and always reads as zero.
// - Nonzero output mode lets compare output override the pin; software sets direction.
// - Non-PWM output modes: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: 2 clears on match sets at bottom, 3 inverse, 1 reserved.
// - Fast PWM with compare at top and upper bit set acts only at bottom.
// - Phase PWM: 2 clears on up match, sets on down match; 3 inverse.
// - Phase PWM with compare at top and upper bit set acts at top.
// - Clock select: 0 stop, 1 undivided, 2..7 divide by 8..1024.
// - Mode bits 6 and 3 give normal, phase PWM, clear-on-match, fast PWM.
// - Top is 0xFF except clear-on-match mode where it is the compare value.
// - Compare update immediate, at top or bottom by mode; overflow flag at max, at bottom in phase PWM.
// - Counter register reads the live count and a write loads the counter.
// - A counter write blocks the compare match on the next timer tick.
// - Registers answer at the I/O offset and at offset plus 0x20 in data space.
// - Compare value checked on every count; a match sets the compare flag.
// - Overflow flag sets on overflow, in phase PWM when reversing at 0x00.
// - Flags clear on vector execution or when software writes a one.

package t0cc_pkg;

    // ==========================================================
    // Register offsets in I/O space
    localparam logic [7:0] OFF_COMPARE     = 8'h31;
    localparam logic [7:0] OFF_COUNTER     = 8'h32;
    localparam logic [7:0] OFF_CONTROL     = 8'h33;
    localparam logic [7:0] OFF_FLAGS       = 8'h36;
    localparam logic [7:0] DATA_SPACE_BASE = 8'h20;

    // ==========================================================
    // Field positions
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_WGM_HI    = 6;
    localparam int CTRL_COM_HI    = 5;
    localparam int CTRL_COM_LO    = 4;
    localparam int CTRL_WGM_LO    = 3;
    localparam int CTRL_CS_HI     = 2;
    localparam int CTRL_CS_LO     = 0;
    localparam int FLAG_CMP_BIT   = 1;
    localparam int FLAG_OVF_BIT   = 0;

    // ==========================================================
    // Values and counts
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam int         PRESC_W      = 10;
    localparam logic [PRESC_W-1:0] DIV_8    = 10'h007;
    localparam logic [PRESC_W-1:0] DIV_32   = 10'h01F;
    localparam logic [PRESC_W-1:0] DIV_64   = 10'h03F;
    localparam logic [PRESC_W-1:0] DIV_128  = 10'h07F;
    localparam logic [PRESC_W-1:0] DIV_256  = 10'h0FF;
    localparam logic [PRESC_W-1:0] DIV_1024 = 10'h3FF;

    // Waveform modes in the order of their combined bit value
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PHASE_PWM,
        MODE_CLEAR_ON_MATCH,
        MODE_FAST_PWM
    } t0cc_mode_type;

endpackage
